// ---- adc_cycle_ctrl.sv ----
// Converter cycle sequencer with two-wire serial slave port
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Cycle conversion, sleep, then addressed input/output
// - Power-up: fast rate, one conversion unasked
// - Sleep after conversion until addressed
// - Sleeping keeps latest result unchanged
// - Refuse address during power-on reset or conversion, else acknowledge
// - Fixed seven-bit address, then direction bit
// - Read shifts sixteen bits, top bit first
// - Write takes exactly one byte, rising edges
// - Last written bit picks slow or fast
// - Convert on stop after transfer, or full read
// - Write, repeat start, read uses new rate
// - Power-on reset interval clears, then converts
// - Slow rate adds offset calibration, twice the time
// - Result clamps to zero and full code
// - Data line only pulled low or released
// - Slave only; clock input only; result only
// - Repeated start acts as start
// - Eight bits then one acknowledge bit
// - Data changes only while clock low
// - Works up to fast-mode bus rates
// - Data line released except data or acknowledge
module adc_cycle_ctrl #(
  parameter int POR_CYCLES = adc_cycle_pkg::POR_CYC,
  parameter int CONV_FAST_CYCLES = adc_cycle_pkg::CONV_FAST_CYC,
  parameter int CONV_SLOW_CYCLES = adc_cycle_pkg::CONV_SLOW_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_mod_valid,
  output logic o_mod_ready,
  input wire logic signed [adc_cycle_pkg::MOD_W-1:0] i_mod_value,
  output logic o_conv_active,
  output logic o_slow_rate_select,
  output logic o_offset_cal
);
  // ==========================================================
  // Declarations
  adc_cycle_pkg::phase_type phase, next_phase;
  adc_cycle_pkg::link_type link, next_link;
  logic [1:0] pins_s;
  logic scl_s, sda_s, scl_d, sda_d;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [3:0] bit_cnt, next_bit_cnt, rd_idx, next_rd_idx;
  logic [7:0] shift_in, next_shift_in;
  logic sda_drive, next_sda_drive;
  logic sel_valid, next_sel_valid, rd_dir, next_rd_dir, wrote, next_wrote;
  logic slow_rate_select, next_slow_rate_select;
  logic conv_slow, next_conv_slow;
  logic [31:0] tmr, next_tmr;
  logic [adc_cycle_pkg::RES_W-1:0] result, next_result;
  logic cal, next_cal;
  logic addr_hit, addr_ack, start_conv, conv_done, fifo_flush;
  logic fifo_valid;
  logic [adc_cycle_pkg::FIFO_W-1:0] fifo_data;

  // Saturate a signed modulator value to the unsigned result range
  function automatic logic [adc_cycle_pkg::RES_W-1:0] clamp_code(
    input logic signed [adc_cycle_pkg::MOD_W-1:0] v);
    if (v < 0) return adc_cycle_pkg::CODE_ZERO;
    if (v > $signed({2'b00, adc_cycle_pkg::CODE_FULL})) return adc_cycle_pkg::CODE_FULL;
    return v[adc_cycle_pkg::RES_W-1:0];
  endfunction

  // ==========================================================
  // Pin sampling; 100 MHz oversamples a 400 kHz clock widely
  pin_sync #(.W(2), .IDLE(2'h3)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_scl, i_sda}),
    .o_sync(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Delayed copies for edge finding
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Clock edges; data moving with clock high marks start or stop
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s;

  // ==========================================================
  // Result buffer between modulator and sequencer
  assign conv_done = (phase == adc_cycle_pkg::PH_CONV) && fifo_valid &&
                     (tmr >= (conv_slow ? 32'(CONV_SLOW_CYCLES - 1) : 32'(CONV_FAST_CYCLES - 1)));
  assign fifo_flush = start_conv || (phase == adc_cycle_pkg::PH_POR);

  word_fifo #(.WIDTH(adc_cycle_pkg::FIFO_W), .DEPTH(adc_cycle_pkg::FIFO_DEPTH)) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_flush(fifo_flush),
    .i_wr_valid(i_mod_valid),
    .o_wr_ready(o_mod_ready),
    .i_wr_data(i_mod_value),
    .o_rd_valid(fifo_valid),
    .i_rd_ready(conv_done),
    .o_rd_data(fifo_data)
  );

  // ==========================================================
  // Serial link next state
  assign addr_hit = (shift_in[7:1] == adc_cycle_pkg::SLAVE_ADDR);
  always_comb begin
    next_link = link;
    next_bit_cnt = bit_cnt;
    next_rd_idx = rd_idx;
    next_shift_in = shift_in;
    next_sda_drive = sda_drive;
    next_sel_valid = sel_valid;
    next_rd_dir = rd_dir;
    next_wrote = wrote;
    next_slow_rate_select = slow_rate_select;
    addr_ack = 1'b0;
    start_conv = 1'b0;
    if (start_det) begin
      next_link = adc_cycle_pkg::L_ADDR;
      next_bit_cnt = '0;
      next_shift_in = '0;
      next_sda_drive = 1'b0;
      next_wrote = 1'b0;
    end else if (stop_det) begin
      next_link = adc_cycle_pkg::L_IDLE;
      next_sda_drive = 1'b0;
      next_sel_valid = 1'b0;
      next_wrote = 1'b0;
      start_conv = sel_valid;
    end else begin
      case (link)
        adc_cycle_pkg::L_ADDR, adc_cycle_pkg::L_WRITE: begin
          if (scl_rise) begin
            next_shift_in = {shift_in[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == adc_cycle_pkg::BYTE_BITS) begin
            next_bit_cnt = '0;
            if (link == adc_cycle_pkg::L_ADDR) begin
              if (addr_hit && (phase == adc_cycle_pkg::PH_SLEEP ||
                  phase == adc_cycle_pkg::PH_IO)) begin
                addr_ack = 1'b1;
                next_sda_drive = 1'b1;
                next_sel_valid = 1'b1;
                next_rd_dir = shift_in[0];
                next_link = adc_cycle_pkg::L_AACK;
              end else begin
                next_link = adc_cycle_pkg::L_IGNORE;
              end
            end else if (!wrote) begin
              next_slow_rate_select = shift_in[0];
              next_wrote = 1'b1;
              next_sda_drive = 1'b1;
              next_link = adc_cycle_pkg::L_WACK;
            end else begin
              next_link = adc_cycle_pkg::L_IGNORE;
            end
          end
        end
        adc_cycle_pkg::L_AACK: begin
          if (scl_fall) begin
            if (rd_dir) begin
              next_link = adc_cycle_pkg::L_READ;
              next_rd_idx = adc_cycle_pkg::RES_TOP_IDX;
              next_sda_drive = !result[adc_cycle_pkg::RES_TOP_IDX];
            end else begin
              next_link = adc_cycle_pkg::L_WRITE;
              next_sda_drive = 1'b0;
            end
          end
        end
        adc_cycle_pkg::L_WACK: begin
          if (scl_fall) begin
            next_sda_drive = 1'b0;
            next_link = adc_cycle_pkg::L_IGNORE;
          end
        end
        adc_cycle_pkg::L_READ: begin
          // Output bits change only on falling clock
          if (scl_fall) begin
            if (rd_idx == '0) begin
              next_sda_drive = 1'b0;
              next_sel_valid = 1'b0;
              next_link = adc_cycle_pkg::L_IGNORE;
              start_conv = 1'b1;
            end else if (rd_idx == adc_cycle_pkg::RES_MID_IDX) begin
              next_sda_drive = 1'b0;
              next_link = adc_cycle_pkg::L_MACK;
            end else begin
              next_rd_idx = rd_idx - 4'h1;
              next_sda_drive = !result[rd_idx - 4'h1];
            end
          end
        end
        adc_cycle_pkg::L_MACK: begin
          if (scl_rise) begin
            next_shift_in = {shift_in[6:0], sda_s};
          end else if (scl_fall) begin
            if (shift_in[0]) begin
              next_link = adc_cycle_pkg::L_IGNORE;
            end else begin
              next_rd_idx = adc_cycle_pkg::RES_LOW_TOP_IDX;
              next_sda_drive = !result[adc_cycle_pkg::RES_LOW_TOP_IDX];
              next_link = adc_cycle_pkg::L_READ;
            end
          end
        end
        adc_cycle_pkg::L_IDLE, adc_cycle_pkg::L_IGNORE: begin
          next_sda_drive = 1'b0;
        end
        default: begin
          next_link = adc_cycle_pkg::L_IDLE;
          next_sda_drive = 1'b0;
        end
      endcase
    end
  end

  // Serial link registers
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      link <= adc_cycle_pkg::L_IDLE;
      bit_cnt <= '0;
      rd_idx <= '0;
      shift_in <= '0;
      sda_drive <= 1'b0;
      sel_valid <= 1'b0;
      rd_dir <= 1'b0;
      wrote <= 1'b0;
      slow_rate_select <= adc_cycle_pkg::RATE_FAST;
    end else begin
      link <= next_link;
      bit_cnt <= next_bit_cnt;
      rd_idx <= next_rd_idx;
      shift_in <= next_shift_in;
      sda_drive <= next_sda_drive;
      sel_valid <= next_sel_valid;
      rd_dir <= next_rd_dir;
      wrote <= next_wrote;
      slow_rate_select <= next_slow_rate_select;
    end
  end

  // ==========================================================
  // Phase sequencer next state
  always_comb begin
    next_phase = phase;
    next_tmr = tmr + 32'h1;
    next_conv_slow = conv_slow;
    next_result = result;
    next_cal = 1'b0;
    case (phase)
      adc_cycle_pkg::PH_POR: begin
        if (tmr >= 32'(POR_CYCLES - 1)) begin
          next_phase = adc_cycle_pkg::PH_CONV;
          next_tmr = '0;
          next_conv_slow = slow_rate_select;
          next_cal = (slow_rate_select == adc_cycle_pkg::RATE_SLOW);
        end
      end
      adc_cycle_pkg::PH_CONV: begin
        if (conv_done) begin
          next_result = clamp_code(fifo_data);
          next_phase = adc_cycle_pkg::PH_SLEEP;
          next_tmr = '0;
        end
      end
      adc_cycle_pkg::PH_SLEEP: begin
        next_tmr = '0;
        if (addr_ack) next_phase = adc_cycle_pkg::PH_IO;
      end
      adc_cycle_pkg::PH_IO: begin
        next_tmr = '0;
        if (start_conv) begin
          next_phase = adc_cycle_pkg::PH_CONV;
          next_conv_slow = next_slow_rate_select;
          next_cal = (next_slow_rate_select == adc_cycle_pkg::RATE_SLOW);
        end
      end
      default: begin
        next_phase = adc_cycle_pkg::PH_POR;
        next_tmr = '0;
      end
    endcase
  end

  // Phase sequencer registers
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      phase <= adc_cycle_pkg::PH_POR;
      tmr <= '0;
      conv_slow <= adc_cycle_pkg::RATE_FAST;
      result <= adc_cycle_pkg::CODE_ZERO;
      cal <= 1'b0;
    end else begin
      phase <= next_phase;
      tmr <= next_tmr;
      conv_slow <= next_conv_slow;
      result <= next_result;
      cal <= next_cal;
    end
  end

  // ==========================================================
  // Outputs; the data line is only ever pulled low
  assign o_sda = 1'b0;
  assign o_sda_oe = sda_drive;
  assign o_conv_active = (phase == adc_cycle_pkg::PH_CONV);
  assign o_slow_rate_select = conv_slow;
  assign o_offset_cal = cal;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_wr_byte;
    link == adc_cycle_pkg::L_WRITE && !wrote && scl_fall && !start_det && !stop_det &&
      bit_cnt == adc_cycle_pkg::BYTE_BITS;
  endsequence
  sequence s_conv_begin;
    phase == adc_cycle_pkg::PH_IO && start_conv;
  endsequence

  property p_no_ack_conv;
    phase == adc_cycle_pkg::PH_CONV || phase == adc_cycle_pkg::PH_POR |-> !o_sda_oe;
  endproperty
  a_no_ack_conv: assert property (p_no_ack_conv) else $error("data line pulled in conversion");
  property p_release;
    o_sda_oe |-> link inside {adc_cycle_pkg::L_AACK, adc_cycle_pkg::L_WACK, adc_cycle_pkg::L_READ};
  endproperty
  a_release: assert property (p_release) else $error("data line pulled outside data or ack");
  property p_sleep_hold;
    phase == adc_cycle_pkg::PH_SLEEP && !addr_ack |=> phase == adc_cycle_pkg::PH_SLEEP && $stable(result);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left or result lost");
  property p_conv_start;
    s_conv_begin |=> phase == adc_cycle_pkg::PH_CONV && conv_slow == $past(next_slow_rate_select);
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("conversion did not start at rate");
  property p_rate_hold;
    phase == adc_cycle_pkg::PH_CONV ##1 phase == adc_cycle_pkg::PH_CONV |-> $stable(conv_slow);
  endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("rate changed mid conversion");
  property p_wr_cfg;
    s_wr_byte |=> slow_rate_select == $past(shift_in[0]) ##1 link == adc_cycle_pkg::L_WACK;
  endproperty
  a_wr_cfg: assert property (p_wr_cfg) else $error("rate byte not taken");
  property p_read_bit;
    link == adc_cycle_pkg::L_READ |-> o_sda_oe == !result[rd_idx];
  endproperty
  a_read_bit: assert property (p_read_bit) else $error("wrong result bit on line");
  property p_restart;
    start_det |=> link == adc_cycle_pkg::L_ADDR && bit_cnt == '0 && !o_sda_oe;
  endproperty
  a_restart: assert property (p_restart) else $error("start did not restart decode");
  property p_mismatch;
    link == adc_cycle_pkg::L_ADDR && scl_fall && !start_det && !stop_det && !addr_hit &&
      bit_cnt == adc_cycle_pkg::BYTE_BITS |=> link == adc_cycle_pkg::L_IGNORE && !o_sda_oe;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("foreign address answered");
  property p_por_end;
    phase == adc_cycle_pkg::PH_POR && tmr >= 32'(POR_CYCLES - 1) |=>
      phase == adc_cycle_pkg::PH_CONV && conv_slow == adc_cycle_pkg::RATE_FAST;
  endproperty
  a_por_end: assert property (p_por_end) else $error("no first conversion after reset");
endmodule
`default_nettype wire

// ---- adc_cycle_pkg.sv ----
// Shared constants and types for the converter control block
package adc_cycle_pkg;
  // Bus address, byte framing, result widths and codes
  localparam logic [6:0] SLAVE_ADDR = 7'h14;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] RES_TOP_IDX = 4'hf;
  localparam logic [3:0] RES_MID_IDX = 4'h8;
  localparam logic [3:0] RES_LOW_TOP_IDX = 4'h7;
  localparam int RES_W = 16;
  localparam int MOD_W = 18;
  localparam int FIFO_W = 18;
  localparam int FIFO_DEPTH = 4;
  localparam logic [15:0] CODE_FULL = 16'hffff;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  // Rate select values
  localparam logic RATE_FAST = 1'b0;
  localparam logic RATE_SLOW = 1'b1;
  // Timing, figures in microseconds and cycles at the system clock
  localparam int CLK_MHZ = 100;
  localparam int POR_US = 500;
  localparam int CONV_FAST_US = 16600;
  localparam int CONV_SLOW_US = 33200;
  localparam int POR_CYC = POR_US * CLK_MHZ;
  localparam int CONV_FAST_CYC = CONV_FAST_US * CLK_MHZ;
  localparam int CONV_SLOW_CYC = CONV_SLOW_US * CLK_MHZ;
  // Device phases and serial link states
  typedef enum logic [1:0] {PH_POR, PH_CONV, PH_SLEEP, PH_IO} phase_type;
  typedef enum logic [2:0] {
    L_IDLE, L_ADDR, L_AACK, L_WRITE, L_WACK, L_READ, L_MACK, L_IGNORE
  } link_type;
endpackage

// ---- pin_sync.sv ----
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] IDLE = '1
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  // ==========================================================
  // Synchroniser stages
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta;
      always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          meta <= IDLE[g];
          o_sync[g] <= IDLE[g];
        end else begin
          meta <= i_async[g];
          o_sync[g] <= meta;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- word_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_flush,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  // ==========================================================
  // Handshake and pointer update
  assign o_wr_ready = (count != (AW+1)'(DEPTH)) && !i_flush;
  assign o_rd_valid = (count != '0);
  assign push = i_wr_valid && o_wr_ready;
  assign pop = o_rd_valid && i_rd_ready && !i_flush;
  assign o_rd_data = mem[rptr];

  always_comb begin
    next_wptr = wptr;
    next_rptr = rptr;
    next_count = count;
    if (i_flush) begin
      next_wptr = '0;
      next_rptr = '0;
      next_count = '0;
    end else begin
      if (push) next_wptr = (wptr == AW'(DEPTH - 1)) ? '0 : wptr + AW'(1);
      if (pop) next_rptr = (rptr == AW'(DEPTH - 1)) ? '0 : rptr + AW'(1);
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
    end
  end

  // Storage
  always_ff @(posedge i_sys_clk) begin
    if (push) mem[wptr] <= i_wr_data;
  end
endmodule
`default_nettype wire

// ---- i2c_master_model.sv ----
// Behavioural two-wire bus master that drives the clock and pulls data low
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
  output logic o_scl,
  output logic o_sda_low,
  input wire logic i_sda
);
  // ==========================================
  // Idle bus
  // Clock stands high and data is released between frames
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // ==========================================
  // Framing
  // Start or repeated start: data falls while clock is high
  task automatic start();
    #25 o_sda_low = 1'b0;
    #25 o_scl = 1'b1;
    #25 o_sda_low = 1'b1;
    #15 o_scl = 1'b0;
  endtask

  // Stop: data rises while clock is high
  task automatic stop();
    #25 o_sda_low = 1'b1;
    #25 o_scl = 1'b1;
    #25 o_sda_low = 1'b0;
    #15;
  endtask

  // ==========================================
  // Bit and byte transfers
  // One 80 ns clock, long low phase so a slave release settles first
  task automatic bit_cycle(input logic drive_low, output logic seen);
    #25 o_sda_low = drive_low;
    #25 o_scl = 1'b1;
    #15 seen = i_sda;
    #15 o_scl = 1'b0;
  endtask

  // Eight bits out, then data released for the slave's answer
  task automatic write_byte(input logic [7:0] b, output logic nack);
    logic s;
    for (int k = 7; k >= 0; k--) begin
      bit_cycle(!b[k], s);
    end
    bit_cycle(1'b0, nack);
  endtask

  // Eight bits in, then our own answer in the ninth clock
  task automatic read_byte(input logic give_ack, output logic [7:0] b);
    logic s;
    for (int k = 7; k >= 0; k--) begin
      bit_cycle(1'b0, s);
      b[k] = s;
    end
    bit_cycle(give_ack, s);
  endtask
endmodule
`default_nettype wire

// ---- tb_adc_cycle_i2c_slave_ctrl.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module tb_adc_cycle_i2c_slave_ctrl;
  localparam int FAST_N = 100;
  localparam int SLOW_N = 200;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic mod_valid = 1'b0;
  logic signed [adc_cycle_pkg::MOD_W-1:0] mod_value = '0;
  logic scl;
  logic sda_low;
  logic sda_dev;
  logic sda_oe;
  logic mod_ready;
  logic conv_active;
  logic slow_sel;
  logic offset_cal;
  wire logic sda_wire;
  int n_fail = 0;
  int total_checks = 0;
  int n_cal = 0;
  logic [7:0] hi;
  logic [7:0] lo;
  logic nack;

  // ==========================================
  // Bus wire, clock and instances
  // Pull-up: line is low only while some party pulls it
  assign sda_wire = (sda_oe ? sda_dev : 1'b1) & !sda_low;
  always #5 sys_clk = ~sys_clk;
  // Calibration pulse counter
  always @(posedge sys_clk) begin
    if (offset_cal === 1'b1) begin
      n_cal <= n_cal + 1;
    end
  end

  adc_cycle_ctrl #(.POR_CYCLES(20), .CONV_FAST_CYCLES(FAST_N), .CONV_SLOW_CYCLES(SLOW_N))
      i_adc_cycle_ctrl (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_scl(scl),
      .i_sda(sda_wire), .o_sda(sda_dev), .o_sda_oe(sda_oe), .i_mod_valid(mod_valid),
      .o_mod_ready(mod_ready), .i_mod_value(mod_value), .o_conv_active(conv_active),
      .o_slow_rate_select(slow_sel), .o_offset_cal(offset_cal));
  i2c_master_model i_i2c_master_model (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda_wire));

  // ==========================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Bounded wait for the conversion flag to reach a level
  task automatic wait_conv(input logic lvl);
    for (int k = 0; k < 5000; k++) begin
      if (conv_active === lvl) return;
      @(negedge sys_clk);
    end
    check(16'(conv_active), 16'(lvl));
    wrap_up();
  endtask

  // Hand one modulator word over, held until ready is seen
  task automatic push_word(input logic signed [17:0] v);
    @(posedge sys_clk);
    mod_valid <= 1'b1;
    mod_value <= v;
    for (int k = 0; k < 50; k++) begin
      @(negedge sys_clk);
      if (mod_ready === 1'b1) begin
        @(posedge sys_clk);
        mod_valid <= 1'b0;
        return;
      end
    end
    check(16'(mod_ready), 16'h0001);
    wrap_up();
  endtask

  task automatic send_addr(input logic [6:0] a, input logic dir, input logic exp_nack);
    i_i2c_master_model.start();
    i_i2c_master_model.write_byte({a, dir}, nack);
    check(16'(nack), 16'(exp_nack));
  endtask

  // Full read of two bytes, master declines after the second
  task automatic do_read(input logic [15:0] exp);
    send_addr(adc_cycle_pkg::SLAVE_ADDR, 1'b1, 1'b0);
    i_i2c_master_model.read_byte(1'b1, hi);
    i_i2c_master_model.read_byte(1'b0, lo);
    check({hi, lo}, exp);
    check(16'(conv_active), 16'h0001);
    i_i2c_master_model.stop();
  endtask

  // Feed one word and time the conversion
  task automatic conv_run(input logic signed [17:0] v, input int n_exp);
    int n;
    n = 0;
    wait_conv(1'b1);
    fork
      push_word(v);
      while (conv_active === 1'b1 && n < 5000) begin
        @(negedge sys_clk);
        n++;
      end
    join
    check(16'(n >= n_exp - 20 && n <= n_exp + 10), 16'h0001);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_power_up();
    check(16'(conv_active), 16'h0000);
    wait_conv(1'b1);
    check(16'(slow_sel), 16'(adc_cycle_pkg::RATE_FAST));
    push_word(18'sh12345);
    send_addr(adc_cycle_pkg::SLAVE_ADDR, 1'b1, 1'b1);
    i_i2c_master_model.stop();
    wait_conv(1'b0);
    $display("test power_up done");
  endtask

  task automatic t_read_fast();
    do_read(16'hffff);
    conv_run(18'sh0abcd, FAST_N);
    repeat (50) @(posedge sys_clk);
    check(16'(conv_active), 16'h0000);
    send_addr(7'h15, 1'b1, 1'b1);
    i_i2c_master_model.stop();
    check(16'(conv_active), 16'h0000);
    $display("test read_fast done");
  endtask

  task automatic t_write_read();
    int cal0;
    cal0 = n_cal;
    send_addr(adc_cycle_pkg::SLAVE_ADDR, 1'b0, 1'b0);
    i_i2c_master_model.write_byte(8'h01, nack);
    check(16'(nack), 16'h0000);
    check(16'(slow_sel), 16'h0000);
    do_read(16'habcd);
    check(16'(slow_sel), 16'(adc_cycle_pkg::RATE_SLOW));
    conv_run(-18'sh00005, SLOW_N);
    check(16'(n_cal - cal0), 16'h0001);
    do_read(16'h0000);
    conv_run(18'sh00007, SLOW_N);
    $display("test write_read done");
  endtask

  task automatic t_one_byte_fill();
    int n;
    n = 0;
    send_addr(adc_cycle_pkg::SLAVE_ADDR, 1'b0, 1'b0);
    i_i2c_master_model.write_byte(8'hfe, nack);
    check(16'(nack), 16'h0000);
    i_i2c_master_model.write_byte(8'hff, nack);
    check(16'(nack), 16'h0001);
    i_i2c_master_model.stop();
    wait_conv(1'b1);
    check(16'(slow_sel), 16'(adc_cycle_pkg::RATE_FAST));
    @(posedge sys_clk);
    mod_valid <= 1'b1;
    mod_value <= 18'sh01111;
    for (int k = 0; k < 12; k++) begin
      @(negedge sys_clk);
      if (mod_ready === 1'b1) begin
        n++;
      end
      @(posedge sys_clk);
      mod_value <= 18'sh02222;
    end
    mod_valid <= 1'b0;
    check(16'(n), 16'h0004);
    wait_conv(1'b0);
    do_read(16'h1111);
    wait_conv(1'b1);
    $display("test one_byte_fill done");
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_power_up();
    t_read_fast();
    t_write_read();
    t_one_byte_fill();
    wrap_up();
  end

  initial begin
    #500000;
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
